// file: hw/cfsq_top.sv
`timescale 1ns/10ps

module cfsq_top #(
    parameter int TICK_COUNT = cfsq_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // command port
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [3:0]  cmd_page,
    input  wire logic [31:0] cmd_wdata,
    output logic             rsp_valid,
    output logic [31:0]      rsp_data,
    // on/off decode inputs
    input  wire logic        operation_on,
    input  wire logic [3:0]  control_input,
    input  wire logic        use_operation,
    input  wire logic        use_control_pins,
    input  wire logic        control_active_high,
    // channel inputs
    input  wire logic [15:0] sense_input_pin,
    input  wire logic [15:0] power_good,
    input  wire logic        alert_enable,
    // shared signature line, open drain
    input  wire logic        chain_signature_in,
    output logic             chain_signature_out,
    output logic             chain_signature_oe,
    // channel results
    output logic [15:0]      power_on_start,
    output logic [15:0]      fault_action_req,
    output logic             alert_active
);
    import cfsq_pkg::*;

    // ****************************************************
    // configuration and status state
    // ****************************************************
    logic [15:0] chan_func  [NCHAN];
    logic [15:0] start_lim  [NCHAN];
    logic [31:0] start_cond [NCHAN];
    logic [15:0] ms_count   [NCHAN];
    logic [15:0] ton_fault, fault_done, started, emit_pend, pg_q;
    logic [15:0] next_ton_fault, next_fault_done, next_started;
    logic [15:0] next_emit_pend, next_fault_req;
    logic [15:0] next_ms_count [NCHAN];
    logic [15:0] next_chan_func [NCHAN];
    logic [15:0] next_start_lim [NCHAN];
    logic [31:0] next_start_cond [NCHAN];
    logic [14:0] tick_cnt, next_tick_cnt;
    logic        tick, vout_summary, next_vout_summary;
    logic        next_rsp_valid;
    logic [31:0] next_rsp_data;

    // per-channel derived levels
    logic [15:0] ready_sig, participates, group_on, emit_ok;
    logic [15:0] start_evt, pg_rise;
    logic [3:0]  start_group;
    logic [3:0]  ctl_level;

    // signature transmit/receive
    cfsq_tx_e    tx_state, next_tx_state;
    cfsq_rx_e    rx_state, next_rx_state;
    logic [3:0]  tx_chan, next_tx_chan;
    logic [3:0]  tx_code, next_tx_code;
    logic [7:0]  tx_cyc, next_tx_cyc, rx_cyc, next_rx_cyc;
    logic [2:0]  tx_slot, next_tx_slot, rx_slot, next_rx_slot;
    logic [3:0]  rx_shift, next_rx_shift;
    logic        rx_hit, next_rx_hit;
    logic [3:0]  rx_code, next_rx_code;
    logic        sig_drive_low;

    // ****************************************************
    // start group decode and channel levels
    // ****************************************************
    // pins may be ignored or polarity-flipped per on/off setup
    always_comb begin
        ctl_level = control_active_high ? control_input : ~control_input;
        for (int g = 0; g < 4; g++) begin
            start_group[g] = (!use_operation || operation_on) &&
                             (!use_control_pins || ctl_level[g]);
        end
    end

    always_comb begin
        for (int c = 0; c < NCHAN; c++) begin
            logic [5:0] fn;
            logic [15:0] mask;
            fn = chan_func[c][FUNC_LSB +: FUNC_W];
            mask = start_cond[c][MASK_LSB +: NCHAN];
            unique case (fn)
                FN_SEQ_VOLT, FN_VOLT_MON: ready_sig[c] = power_good[c];
                FN_GPI_LOW:  ready_sig[c] = ~sense_input_pin[c];
                FN_GPI_HIGH: ready_sig[c] = sense_input_pin[c];
                default:     ready_sig[c] = 1'b0;
            endcase
            // only disabled channels can never satisfy a combine; read-only ones can
            participates[c] = (fn != FN_DISABLED);
            emit_ok[c] = (fn == FN_SEQ_VOLT) || (fn == FN_VOLT_MON) ||
                         (fn == FN_GPI_LOW) || (fn == FN_GPI_HIGH);
            group_on[c] = start_group[start_cond[c][GROUP_LSB +: 2]];
            unique case (start_cond[c][MODE_LSB +: 2])
                START_BY_GROUP: start_evt[c] = group_on[c];
                START_BY_AND:   start_evt[c] = participates[c] &&
                    ((mask & ~ready_sig) == 16'h0000);
                START_BY_SIG:   start_evt[c] = participates[c] && rx_hit &&
                    (start_cond[c][CMP_LSB +: SIG_W] != 4'h0) &&
                    (start_cond[c][CMP_LSB +: SIG_W] == rx_code);
                default:        start_evt[c] = 1'b0;
            endcase
            pg_rise[c] = ready_sig[c] && !pg_q[c];
        end
    end

    // ****************************************************
    // command handling, start latch and timeout
    // ****************************************************
    always_comb begin
        next_tick_cnt = (tick_cnt == 15'(TICK_COUNT - 1)) ? 15'h0000
                        : tick_cnt + 15'h0001;
        tick = (tick_cnt == 15'(TICK_COUNT - 1));
        next_vout_summary = vout_summary;
        next_rsp_valid = cmd_valid && !cmd_write;
        next_rsp_data = 32'h0000_0000;
        next_fault_req = 16'h0000;
        for (int c = 0; c < NCHAN; c++) begin
            next_chan_func[c] = chan_func[c];
            next_start_lim[c] = start_lim[c];
            next_start_cond[c] = start_cond[c];
            // a group drop ends the attempt and rearms timer and fault
            next_started[c] = group_on[c] && (started[c] || start_evt[c]);
            next_fault_done[c] = group_on[c] && fault_done[c];
            next_ms_count[c] = (!group_on[c] || started[c]) ? 16'h0000
                : ms_count[c] + {15'h0000, tick && ms_count[c] != 16'hFFFF};
            next_ton_fault[c] = ton_fault[c];
            next_emit_pend[c] = emit_pend[c] ||
                (pg_rise[c] && emit_ok[c] &&
                 chan_func[c][EMIT_LSB +: SIG_W] != 4'h0);
        end
        if (cmd_valid && cmd_write) begin
            unique case (cmd_code)
                CMD_CHAN_FUNC:   next_chan_func[cmd_page] =
                    cmd_wdata[15:0] & FUNC_CFG_MASK;
                CMD_START_LIMIT: next_start_lim[cmd_page] = cmd_wdata[15:0];
                CMD_START_COND:  next_start_cond[cmd_page] =
                    cmd_wdata & COND_CFG_MASK;
                CMD_CLEAR_FAULTS: begin
                    next_ton_fault = 16'h0000;
                    next_vout_summary = 1'b0;
                end
                default: ;
            endcase
        end
        // timeout set is applied after the clear so a same-cycle event wins
        for (int c = 0; c < NCHAN; c++) begin
            if (group_on[c] && !started[c] && !fault_done[c] &&
                start_lim[c] != 16'h0000 &&
                ms_count[c] > start_lim[c]) begin
                next_ton_fault[c] = 1'b1;
                next_vout_summary = 1'b1;
                next_fault_done[c] = 1'b1;
                next_fault_req[c] = 1'b1;
            end
        end
        if (tx_state == CFSQ_TX_IDLE && next_tx_state == CFSQ_TX_SEND)
            next_emit_pend[next_tx_chan] = 1'b0;
        if (cmd_valid && !cmd_write) begin
            unique case (cmd_code)
                CMD_CHAN_FUNC:   next_rsp_data = {16'h0000, chan_func[cmd_page]};
                CMD_START_LIMIT: next_rsp_data = {16'h0000, start_lim[cmd_page]};
                CMD_START_COND:  next_rsp_data = start_cond[cmd_page];
                CMD_STATUS_WORD: next_rsp_data =
                    32'(vout_summary) << VOUT_SUMMARY_BIT;
                CMD_STATUS_VOUT: next_rsp_data =
                    32'(ton_fault[cmd_page]) << TON_FAULT_BIT;
                CMD_READ_VOUT: begin
                    // analog readback lives elsewhere; only general inputs here
                    if (chan_func[cmd_page][FUNC_LSB +: FUNC_W] == FN_GPI_LOW ||
                        chan_func[cmd_page][FUNC_LSB +: FUNC_W] == FN_GPI_HIGH)
                        next_rsp_data = {16'h0000, ready_sig[cmd_page] ?
                            GPI_ACTIVE_READ : GPI_IDLE_READ};
                end
                default: next_rsp_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int c = 0; c < NCHAN; c++) begin
                chan_func[c]  <= CHAN_FUNC_RESET;
                start_lim[c]  <= START_LIM_RESET;
                start_cond[c] <= START_CND_RESET;
                ms_count[c]   <= 16'h0000;
            end
            tick_cnt         <= 15'h0000;
            ton_fault        <= 16'h0000;
            fault_done       <= 16'h0000;
            started          <= 16'h0000;
            emit_pend        <= 16'h0000;
            pg_q             <= 16'h0000;
            fault_action_req <= 16'h0000;
            vout_summary     <= 1'b0;
            rsp_valid        <= 1'b0;
            rsp_data         <= 32'h0000_0000;
        end else begin
            chan_func        <= next_chan_func;
            start_lim        <= next_start_lim;
            start_cond       <= next_start_cond;
            ms_count         <= next_ms_count;
            tick_cnt         <= next_tick_cnt;
            ton_fault        <= next_ton_fault;
            fault_done       <= next_fault_done;
            started          <= next_started;
            emit_pend        <= next_emit_pend;
            pg_q             <= ready_sig;
            fault_action_req <= next_fault_req;
            vout_summary     <= next_vout_summary;
            rsp_valid        <= next_rsp_valid;
            rsp_data         <= next_rsp_data;
        end
    end

    assign power_on_start = started;
    assign alert_active   = alert_enable && (ton_fault != 16'h0000);

    // ****************************************************
    // signature line: start slot low, four bits lsb first, guard
    // ****************************************************
    // one frame at a time; lowest pending channel goes first
    always_comb begin
        next_tx_state = tx_state;
        next_tx_chan = tx_chan;
        next_tx_code = tx_code;
        next_tx_cyc = tx_cyc;
        next_tx_slot = tx_slot;
        for (int c = NCHAN - 1; c >= 0; c--) begin
            if (emit_pend[c])
                next_tx_chan = 4'(c);
        end
        unique case (tx_state)
            CFSQ_TX_IDLE: begin
                if (emit_pend != 16'h0000 && rx_state == CFSQ_RX_IDLE) begin
                    next_tx_state = CFSQ_TX_SEND;
                    next_tx_code = chan_func[next_tx_chan][EMIT_LSB +: SIG_W];
                    next_tx_cyc = 8'h00;
                    next_tx_slot = 3'h0;
                end
            end
            CFSQ_TX_SEND: begin
                next_tx_cyc = tx_cyc + 8'h01;
                if (tx_cyc == 8'(SIG_SLOT_CYCLES - 1)) begin
                    next_tx_cyc = 8'h00;
                    next_tx_slot = tx_slot + 3'h1;
                    if (tx_slot == 3'(SIG_SLOTS - 1))
                        next_tx_state = CFSQ_TX_IDLE;
                end
            end
        endcase
        sig_drive_low = (tx_state == CFSQ_TX_SEND) && ((tx_slot == 3'h0) ||
            (tx_slot >= 3'h1 && tx_slot <= 3'h4 &&
             !tx_code[2'(tx_slot - 3'h1)]));
    end

    // receive samples mid-slot; own frames are heard too
    always_comb begin
        next_rx_state = rx_state;
        next_rx_cyc = rx_cyc;
        next_rx_slot = rx_slot;
        next_rx_shift = rx_shift;
        next_rx_hit = 1'b0;
        next_rx_code = rx_code;
        unique case (rx_state)
            CFSQ_RX_IDLE: begin
                if (!chain_signature_in) begin
                    next_rx_state = CFSQ_RX_RECV;
                    next_rx_cyc = 8'h01;
                    next_rx_slot = 3'h0;
                end
            end
            CFSQ_RX_RECV: begin
                next_rx_cyc = rx_cyc + 8'h01;
                if (rx_cyc == 8'(SIG_SLOT_CYCLES / 2) && rx_slot != 3'h0)
                    next_rx_shift = {chain_signature_in, rx_shift[3:1]};
                if (rx_cyc == 8'(SIG_SLOT_CYCLES - 1)) begin
                    next_rx_cyc = 8'h00;
                    next_rx_slot = rx_slot + 3'h1;
                    if (rx_slot == 3'h4) begin
                        next_rx_state = CFSQ_RX_IDLE;
                        next_rx_hit = 1'b1;
                        next_rx_code = rx_shift;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_state            <= CFSQ_TX_IDLE;
            tx_chan             <= 4'h0;
            tx_code             <= 4'h0;
            tx_cyc              <= 8'h00;
            tx_slot             <= 3'h0;
            rx_state            <= CFSQ_RX_IDLE;
            rx_cyc              <= 8'h00;
            rx_slot             <= 3'h0;
            rx_shift            <= 4'h0;
            rx_hit              <= 1'b0;
            rx_code             <= 4'h0;
            chain_signature_oe  <= 1'b0;
        end else begin
            tx_state            <= next_tx_state;
            tx_chan             <= next_tx_chan;
            tx_code             <= next_tx_code;
            tx_cyc              <= next_tx_cyc;
            tx_slot             <= next_tx_slot;
            rx_state            <= next_rx_state;
            rx_cyc              <= next_rx_cyc;
            rx_slot             <= next_rx_slot;
            rx_shift            <= next_rx_shift;
            rx_hit              <= next_rx_hit;
            rx_code             <= next_rx_code;
            chain_signature_oe  <= sig_drive_low;
        end
    end

    // open drain: only ever pulls low
    assign chain_signature_out = 1'b0;

endmodule

// file: hw/cfsq_pkg.sv
package cfsq_pkg;

    // ****************************************************
    // command codes and register fields
    // ****************************************************
    localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
    localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
    localparam logic [7:0] CMD_STATUS_VOUT   = 8'h7A;
    localparam logic [7:0] CMD_READ_VOUT     = 8'h8B;
    localparam logic [7:0] CMD_CHAN_FUNC     = 8'hE4;
    localparam logic [7:0] CMD_START_LIMIT   = 8'hE6;
    localparam logic [7:0] CMD_START_COND    = 8'hE8;

    localparam int NCHAN                     = 16;
    localparam int FUNC_LSB                  = 0;
    localparam int FUNC_W                    = 6;
    localparam int EMIT_LSB                  = 8;
    localparam int SIG_W                     = 4;
    localparam int GROUP_LSB                 = 0;
    localparam int MODE_LSB                  = 4;
    localparam int CMP_LSB                   = 8;
    localparam int MASK_LSB                  = 16;
    localparam int VOUT_SUMMARY_BIT          = 15;
    localparam int TON_FAULT_BIT             = 4;

    localparam logic [15:0] FUNC_CFG_MASK    = 16'h0F3F;
    localparam logic [31:0] COND_CFG_MASK    = 32'hFFFF_0F33;
    localparam logic [15:0] CHAN_FUNC_RESET  = 16'h0000;
    localparam logic [15:0] START_LIM_RESET  = 16'h0000;
    localparam logic [31:0] START_CND_RESET  = 32'h0000_0000;
    localparam logic [15:0] GPI_ACTIVE_READ  = 16'h0001;
    localparam logic [15:0] GPI_IDLE_READ    = 16'h0000;

    // channel function codes
    localparam logic [5:0] FN_DISABLED       = 6'h00;
    localparam logic [5:0] FN_SEQ_VOLT       = 6'h10;
    localparam logic [5:0] FN_VOLT_MON       = 6'h20;
    localparam logic [5:0] FN_VOLT_READ      = 6'h21;
    localparam logic [5:0] FN_CURR_MON       = 6'h22;
    localparam logic [5:0] FN_CURR_READ      = 6'h23;
    localparam logic [5:0] FN_GPI_LOW        = 6'h30;
    localparam logic [5:0] FN_GPI_HIGH       = 6'h34;

    // start selection codes
    localparam logic [1:0] START_BY_GROUP    = 2'b00;
    localparam logic [1:0] START_BY_AND      = 2'b01;
    localparam logic [1:0] START_BY_SIG      = 2'b10;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_HZ                    = 25000000;
    localparam int TICK_MS                   = 1;
    localparam int TICK_CYCLES               = CLK_HZ / 1000 * TICK_MS;
    localparam int SIG_SLOT_CYCLES           = 8;
    localparam int SIG_SLOTS                 = 6;

    typedef enum logic [1:0] {
        CFSQ_TX_IDLE = 2'b01,
        CFSQ_TX_SEND = 2'b10
    } cfsq_tx_e;

    typedef enum logic [1:0] {
        CFSQ_RX_IDLE = 2'b01,
        CFSQ_RX_RECV = 2'b10
    } cfsq_rx_e;

endpackage

// file: tb/cfsq_top_chk.sv
`timescale 1ns/10ps
module cfsq_top_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // command port
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_data,
    // channel side
    input wire logic        alert_enable,
    input wire logic        chain_signature_out,
    input wire logic        chain_signature_oe,
    input wire logic [15:0] fault_action_req,
    input wire logic        alert_active
);
    import cfsq_pkg::*;
    // ****************************************************
    // one clock domain, reset disables everything
    // ****************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // only a read earns an answer, and exactly one cycle later
    a_read_answer: assert property (cmd_valid && !cmd_write |=> rsp_valid
        ##1 !rsp_valid || $past(cmd_valid) && !$past(cmd_write))
        else $error("read answer missing or too long");
    a_no_stray_rsp: assert property (!(cmd_valid && !cmd_write)
        |=> !rsp_valid) else $error("answer without a read");
    a_func_zero_bits: assert property (rsp_valid && $past(cmd_code) ==
        CMD_CHAN_FUNC |-> (rsp_data & ~{16'h0000, FUNC_CFG_MASK}) == 32'h0)
        else $error("function word reserved bits set");
    a_cond_zero_bits: assert property (rsp_valid && $past(cmd_code) ==
        CMD_START_COND |-> (rsp_data & ~COND_CFG_MASK) == 32'h0)
        else $error("start word reserved bits set");
    a_gpi_read_range: assert property (rsp_valid && $past(cmd_code) ==
        CMD_READ_VOUT |-> rsp_data[31:1] == 31'h0)
        else $error("readback beyond one bit");
    // open drain: data pin never drives high, frame opens with a full slot
    a_sig_open_drain: assert property (chain_signature_out == 1'h0)
        else $error("signature pin driven high");
    a_frame_start: assert property ($rose(chain_signature_oe)
        |-> chain_signature_oe[*8]) else $error("short start slot");
    a_fault_single: assert property (fault_action_req != 16'h0 |=>
        (fault_action_req & $past(fault_action_req)) == 16'h0)
        else $error("fault request longer than a pulse");
    a_fault_alert: assert property (fault_action_req != 16'h0 &&
        alert_enable |-> ##[0:1] alert_active)
        else $error("timeout without alert");
    a_alert_gate: assert property (alert_active |-> alert_enable)
        else $error("alert while disabled");
endmodule
bind cfsq_top cfsq_top_chk u_chk (.ref_clk, .resetn, .cmd_valid,
    .cmd_write, .cmd_code, .rsp_valid, .rsp_data, .alert_enable,
    .chain_signature_out, .chain_signature_oe, .fault_action_req,
    .alert_active);

// file: tb/cfsq_peer.sv
`timescale 1ns/10ps
module cfsq_peer (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // request from bench
    input  wire logic       send,
    input  wire logic [3:0] code,
    // shared wire, pulled up
    input  wire logic       dut_oe,
    output logic            sig_wire
);
    logic       busy;
    logic [5:0] cyc;
    logic [3:0] sig;
    logic       peer_oe;
    // ****************************************************
    // peer frame: 6 slots of 8, low start, bits lsb first
    // ****************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'h0;
            cyc <= 6'h00;
        end else if (busy) begin
            busy <= cyc != 6'h2F;
            cyc <= cyc + 6'h01;
        end else if (send) begin
            busy <= 1'h1;
            cyc <= 6'h00;
            sig <= code;
        end
    end
    // a zero bit pulls low, a one lets the pull-up win
    assign peer_oe = busy && (cyc[5:3] == 3'h0 ||
        (cyc[5:3] <= 3'h4 && !sig[cyc[5:3] - 3'h1]));
    assign sig_wire = !(dut_oe || peer_oe);
endmodule

// file: tb/cfsq_top_tb.sv
`timescale 1ns/10ps
module cfsq_top_tb;
    import cfsq_pkg::*;
    logic        ref_clk = 1'h0;
    logic        resetn = 1'h0;
    logic        cmd_valid = 1'h0;
    logic        cmd_write = 1'h0;
    logic [7:0]  cmd_code = 8'h00;
    logic [3:0]  cmd_page = 4'h0;
    logic [31:0] cmd_wdata = 32'h0;
    logic        operation_on = 1'h1;
    logic [3:0]  control_input = 4'hF;
    logic        use_operation = 1'h1;
    logic        use_control_pins = 1'h1;
    logic        control_active_high = 1'h1;
    logic [15:0] sense_input_pin = 16'h0000;
    logic [15:0] power_good = 16'h0000;
    logic        alert_enable = 1'h1;
    logic        send = 1'h0;
    logic [3:0]  code = 4'h0;
    logic        sig_wire, sig_out, sig_oe, rsp_valid, alert_active;
    logic [31:0] rsp_data;
    logic [15:0] power_on_start, fault_action_req;
    logic [15:0] fault_seen = 16'h0000;
    int          failures = 0;
    int          checks_done = 0;
    always #20 ref_clk = ~ref_clk;
    // sticky record of timeout pulses, they last one cycle
    always @(posedge ref_clk) fault_seen <= fault_seen | fault_action_req;
    cfsq_top #(.TICK_COUNT(10)) u_dut (.ref_clk, .resetn, .cmd_valid,
        .cmd_write, .cmd_code, .cmd_page, .cmd_wdata, .rsp_valid,
        .rsp_data, .operation_on, .control_input, .use_operation,
        .use_control_pins, .control_active_high, .sense_input_pin,
        .power_good, .alert_enable, .chain_signature_in(sig_wire),
        .chain_signature_out(sig_out), .chain_signature_oe(sig_oe),
        .power_on_start, .fault_action_req, .alert_active);
    cfsq_peer u_peer (.ref_clk, .resetn, .send, .code, .dut_oe(sig_oe),
        .sig_wire);
    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one command, then one idle cycle so the answer has landed
    task automatic cmd(input logic w, input logic [7:0] c,
                       input logic [3:0] p, input logic [31:0] d);
        cmd_valid <= 1'h1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_page <= p;
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'h0;
        @(posedge ref_clk);
    endtask
    // sel 0 start bit, 1 timeout pulse, 2 signature drive
    task automatic expect_within(input int sel, input int ch, input int n,
                                 input logic exp);
        logic hit;
        hit = 1'h0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            hit = hit | (sel == 0 ? power_on_start[ch] :
                         sel == 1 ? fault_seen[ch] : sig_oe);
        end
        @(posedge ref_clk);
        check({31'h0, hit}, {31'h0, exp});
        if (exp && !hit) conclude();
    endtask
    task automatic send_sig(input logic [3:0] c);
        code <= c;
        send <= 1'h1;
        @(posedge ref_clk);
        send <= 1'h0;
    endtask
    // ****************************************************
    // scenarios; supplies held off while configuring, except in t_gpi and t_emit
    // ****************************************************
    task automatic t_regs();
        control_input <= 4'h0;
        cmd(0, CMD_START_LIMIT, 4'h9, 32'h0);
        check(rsp_data, {16'h0000, START_LIM_RESET});
        cmd(1, CMD_CHAN_FUNC, 4'h3, 32'hFFFF_FFFF);
        cmd(0, CMD_CHAN_FUNC, 4'h3, 32'h0);
        check(rsp_data, 32'h0000_0F3F);
        cmd(1, CMD_START_COND, 4'h3, 32'hFFFF_FFFF);
        cmd(0, CMD_START_COND, 4'h3, 32'h0);
        check(rsp_data, 32'hFFFF_0F33);
        cmd(0, 8'h55, 4'h0, 32'h0);
        check(rsp_data, 32'h0);
        control_input <= 4'hF;
        expect_within(0, 3, 10, 1'h0);
    endtask
    task automatic t_gpi();
        logic [5:0] fn [5] = '{6'h34, 6'h34, 6'h30, 6'h30, 6'h21};
        logic       pin [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
        logic [1:0] exp [5] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h0};
        for (int i = 0; i < 5; i++) begin
            cmd(1, CMD_CHAN_FUNC, 4'h5, {26'h0, fn[i]});
            sense_input_pin[5] <= pin[i];
            repeat (3) @(posedge ref_clk);
            cmd(0, CMD_READ_VOUT, 4'h5, 32'h0);
            check(rsp_data, {30'h0, exp[i]});
        end
    endtask
    task automatic t_group();
        control_input <= 4'h0;
        cmd(1, CMD_START_COND, 4'h0, 32'h0000_0002);
        control_input <= 4'hB;
        expect_within(0, 0, 6, 1'h0);
        control_input <= 4'h4;
        expect_within(0, 0, 3, 1'h1);
        operation_on <= 1'h0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, power_on_start[0]}, 32'h0);
        operation_on <= 1'h1;
    endtask
    task automatic t_and();
        control_input <= 4'h0;
        cmd(1, CMD_CHAN_FUNC, 4'h1, 32'h0000_0020);
        cmd(1, CMD_CHAN_FUNC, 4'h2, 32'h0000_0020);
        cmd(1, CMD_START_COND, 4'h1, 32'h0006_0010);
        control_input <= 4'hF;
        power_good <= 16'h8002;
        expect_within(0, 1, 10, 1'h0);
        power_good <= 16'h0006;
        expect_within(0, 1, 5, 1'h1);
    endtask
    task automatic t_sig();
        control_input <= 4'h0;
        cmd(1, CMD_CHAN_FUNC, 4'h6, 32'h0000_0020);
        cmd(1, CMD_START_COND, 4'h6, 32'h0000_0520);
        control_input <= 4'hF;
        send_sig(4'h3);
        expect_within(0, 6, 60, 1'h0);
        send_sig(4'h5);
        expect_within(0, 6, 60, 1'h1);
    endtask
    task automatic t_emit();
        cmd(1, CMD_CHAN_FUNC, 4'h8, 32'h0000_0900);
        cmd(1, CMD_CHAN_FUNC, 4'h7, 32'h0000_0910);
        power_good[8] <= 1'h1;
        expect_within(2, 0, 60, 1'h0);
        power_good[7] <= 1'h1;
        for (int i = 0; i < 40 && !sig_oe; i++) begin
            @(posedge ref_clk);
            #1;
        end
        check({31'h0, sig_oe}, 32'h1);
        if (!sig_oe) conclude();
        // signature 9 is 1001, mid-slot levels lsb first
        for (int k = 0; k < 4; k++) begin
            repeat (k == 0 ? 12 : 8) @(posedge ref_clk);
            #1;
            check({31'h0, sig_wire}, {31'h0, k == 0 || k == 3});
        end
        @(posedge ref_clk);
    endtask
    task automatic t_timeout();
        control_input <= 4'h0;
        cmd(1, CMD_CHAN_FUNC, 4'h4, 32'h0000_0020);
        cmd(1, CMD_START_COND, 4'h2, 32'h8000_0010);
        cmd(1, CMD_START_COND, 4'h4, 32'h8000_0010);
        cmd(1, CMD_START_LIMIT, 4'h2, 32'h0000_0002);
        control_input <= 4'hF;
        expect_within(1, 2, 18, 1'h0);
        expect_within(1, 2, 50, 1'h1);
        check({31'h0, alert_active}, 32'h1);
        check({31'h0, fault_seen[4]}, 32'h0);
        cmd(0, CMD_STATUS_WORD, 4'h0, 32'h0);
        check({31'h0, rsp_data[VOUT_SUMMARY_BIT]}, 32'h1);
        cmd(0, CMD_STATUS_VOUT, 4'h2, 32'h0);
        check({31'h0, rsp_data[TON_FAULT_BIT]}, 32'h1);
        cmd(1, CMD_CLEAR_FAULTS, 4'h2, 32'h0);
        cmd(0, CMD_STATUS_VOUT, 4'h2, 32'h0);
        check({31'h0, rsp_data[TON_FAULT_BIT]}, 32'h0);
        check({31'h0, alert_active}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'h1;
        @(posedge ref_clk);
        t_regs();
        t_gpi();
        t_group();
        t_and();
        t_sig();
        t_emit();
        t_timeout();
        conclude();
    end
endmodule
